// ==== rtl/status_pkg.sv ====
// Shared layouts, offsets and codes for the ALU flag and reset-cause bank
package status_pkg;

  //--------------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  //--------------------------------------------------------------------
  localparam logic [11:0] FLAGS_OFFSET       = 12'h000;
  localparam logic [11:0] RESET_CAUSE_OFFSET = 12'h004;

  //--------------------------------------------------------------------
  // Reset values and write masks
  //--------------------------------------------------------------------
  localparam logic [7:0] ALU_FLAGS_RESET        = 8'h00;
  localparam logic [7:0] ALU_FLAGS_WRITE_MASK   = 8'h1F;
  localparam logic [7:0] RESET_CAUSE_RESET      = 8'h1C;
  localparam logic [7:0] RESET_CAUSE_WRITE_MASK = 8'h93;

  //--------------------------------------------------------------------
  // Bus answers
  //--------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  //--------------------------------------------------------------------
  // Field layouts, bit 7 first
  //--------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] unused;
    logic       negative;
    logic       signed_wrap_flag;
    logic       zero;
    logic       nibble_carry;
    logic       carry;
  } alu_flags_type;

  typedef struct packed {
    logic       irq_priority_enable;
    logic [1:0] unused;
    logic       soft_reset_flag;
    logic       watchdog_expiry_flag;
    logic       sleep_entry_flag;
    logic       power_up_reset_flag;
    logic       low_voltage_reset_flag;
  } reset_cause_type;

  //--------------------------------------------------------------------
  // Core-side operations and events
  //--------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE                   = 4'h0,
    ACCUMULATOR_ADD_OP        = 4'h1,
    ACCUMULATOR_SUBTRACT_OP   = 4'h2,
    OP_AND                    = 4'h3,
    OP_OR                     = 4'h4,
    OP_XOR                    = 4'h5,
    CLEAR_FILE_OP             = 4'h6,
    BIT_SET_OP                = 4'h7,
    BIT_CLEAR_OP              = 4'h8,
    NIBBLE_EXCHANGE_OP        = 4'h9,
    FILE_TO_FILE_MOVE_OP      = 4'hA,
    ACCUMULATOR_STORE_OP      = 4'hB
  } op_code_type;

  typedef struct packed {
    logic        valid;
    op_code_type code;
    logic        dest_is_flags;
    logic [7:0]  operand_a;
    logic [7:0]  operand_b;
  } op_req_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } op_result_type;

  typedef struct packed {
    logic soft_reset;
    logic watchdog_timeout;
    logic sleep;
    logic watchdog_kick;
    logic brownout;
  } reset_event_type;

endpackage

// ==== rtl/alu_flag_logic.sv ====
// Combinational result and flag computation for one core operation
`timescale 1ns/100ps
module alu_flag_logic (
  input  wire status_pkg::op_req_type    op,
  input  wire status_pkg::alu_flags_type flags_now,
  output logic [7:0]                     result,
  output status_pkg::alu_flags_type      flags_new,
  output logic                           affects_flags
);

  logic       is_sub;
  logic [7:0] b_eff;
  logic [8:0] sum9;
  logic [4:0] nib5;

  // Subtract adds the two's complement, so carries are inverted borrows
  assign is_sub = (op.code == status_pkg::ACCUMULATOR_SUBTRACT_OP); // [RL5]
  assign b_eff  = is_sub ? ~op.operand_b : op.operand_b; // [RL5]
  assign sum9   = {1'b0, op.operand_a} + {1'b0, b_eff} + {8'h00, is_sub};
  assign nib5   = {1'b0, op.operand_a[3:0]} + {1'b0, b_eff[3:0]}
                + {4'h0, is_sub};

  // Result and flag effects per operation
  always_comb begin
    result        = 8'h00;
    flags_new     = flags_now;
    affects_flags = 1'b0;
    unique case (op.code)
      status_pkg::ACCUMULATOR_ADD_OP,
      status_pkg::ACCUMULATOR_SUBTRACT_OP: begin
        result                     = sum9[7:0];
        affects_flags              = 1'b1;
        flags_new.carry            = sum9[8]; // [RL9]
        flags_new.nibble_carry     = nib5[4]; // [RL8]
        flags_new.signed_wrap_flag = (op.operand_a[7] == b_eff[7]) &&
                                     (sum9[7] != op.operand_a[7]); // [RL6]
        flags_new.negative         = sum9[7]; // [RL10]
        flags_new.zero             = (sum9[7:0] == 8'h00); // [RL7]
      end
      status_pkg::OP_AND,
      status_pkg::OP_OR,
      status_pkg::OP_XOR: begin
        if (op.code == status_pkg::OP_AND) begin
          result = op.operand_a & op.operand_b;
        end else if (op.code == status_pkg::OP_OR) begin
          result = op.operand_a | op.operand_b;
        end else begin
          result = op.operand_a ^ op.operand_b;
        end
        affects_flags      = 1'b1;
        flags_new.negative = result[7];
        flags_new.zero     = (result == 8'h00); // [RL7]
      end
      status_pkg::CLEAR_FILE_OP: begin
        affects_flags  = 1'b1;
        flags_new.zero = 1'b1; // [RL3]
      end
      // No flag effect from these, so they can safely edit the flags
      status_pkg::BIT_SET_OP:
        result = op.operand_a | (8'h01 << op.operand_b[2:0]); // [RL4]
      status_pkg::BIT_CLEAR_OP:
        result = op.operand_a & ~(8'h01 << op.operand_b[2:0]); // [RL4]
      status_pkg::NIBBLE_EXCHANGE_OP:
        result = {op.operand_a[3:0], op.operand_a[7:4]}; // [RL4]
      status_pkg::FILE_TO_FILE_MOVE_OP:
        result = op.operand_a; // [RL4]
      status_pkg::ACCUMULATOR_STORE_OP:
        result = op.operand_b; // [RL4]
      default: result = 8'h00;
    endcase
    flags_new.unused = 3'h0; // [RL10]
  end

endmodule

// ==== rtl/reset_cause_keeper.sv ====
// Reset-cause register with hardware events and firmware writes
`timescale 1ns/100ps
module reset_cause_keeper (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    brownout_reset_enable,
  input  wire status_pkg::reset_event_type events,
  input  wire logic                    fw_write,
  input  wire logic [7:0]              fw_data,
  output status_pkg::reset_cause_type  cause
);

  logic [7:0] merged;

  // Only priority enable, soft, power-up and low-voltage are writable
  assign merged = (fw_data & status_pkg::RESET_CAUSE_WRITE_MASK) |
                  (cause & ~status_pkg::RESET_CAUSE_WRITE_MASK); // [RL20]

  // Events are applied after the write so hardware wins a collision
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause <= status_pkg::RESET_CAUSE_RESET; // [RL11] [RL16]
      cause.low_voltage_reset_flag <= brownout_reset_enable; // [RL19]
    end else begin
      if (fw_write) begin
        cause <= status_pkg::reset_cause_type'(merged); // [RL13] [RL17]
      end
      if (events.soft_reset) begin
        cause.soft_reset_flag <= 1'b0; // [RL13]
      end
      if (events.brownout) begin
        cause.low_voltage_reset_flag <= 1'b0; // [RL18]
      end
      if (events.watchdog_kick) begin
        cause.watchdog_expiry_flag <= 1'b1; // [RL14]
        cause.sleep_entry_flag     <= 1'b1; // [RL15]
      end
      if (events.sleep) begin
        cause.watchdog_expiry_flag <= 1'b1; // [RL14]
        cause.sleep_entry_flag     <= 1'b0; // [RL15]
      end
      // A time-out outranks a kick in the same cycle
      if (events.watchdog_timeout) begin
        cause.watchdog_expiry_flag <= 1'b0; // [RL14]
      end
    end
  end

endmodule

// ==== rtl/alu_status_reset_cause.sv ====
// ALU flag and reset-cause register bank with an AXI4-Lite slave port
//
// Notes on behaviour
// RL1: Flag register usable as any operand.
// RL2: Flag-changing op into flags keeps flags only.
// RL3: Clear-file on flags sets zero only.
// RL4: Bit set/clear, swap, moves never touch flags.
// RL5: Subtract carries are inverted borrows.
// RL6: Signed wrap flag marks sign overflow.
// RL7: Zero flag marks a zero result.
// RL8: Nibble carry from bit 3 on add/subtract.
// RL9: Carry from bit 7 on add/subtract.
// RL10: Negative copies result MSB; bits 7-5 zero.
// RL11: Priority enable bit, resets to zero.
// RL12: Reset-cause bits 6 and 5 read zero.
// RL13: Reset instruction clears soft-reset flag.
// RL14: Watchdog flag: time-out clears, kick/sleep set.
// RL15: Sleep flag: kick sets, sleep clears.
// RL16: Power-on reset clears power-up flag.
// RL17: Firmware should set power-up flag afterwards.
// RL18: Brown-out clears low-voltage flag until rewritten.
// RL19: Brown-out enabled: low-voltage flag one at power-on.
// RL20: Reset-cause writable except read-only bits.
`timescale 1ns/100ps
module alu_status_reset_cause (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // AXI4-Lite write address
  input  wire logic [11:0]                 awaddr,
  input  wire logic [2:0]                  awprot,
  input  wire logic                        awvalid,
  output logic                             awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  // AXI4-Lite write response
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  // AXI4-Lite read address
  input  wire logic [11:0]                 araddr,
  input  wire logic [2:0]                  arprot,
  input  wire logic                        arvalid,
  output logic                             arready,
  // AXI4-Lite read data
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  // Core side
  input  wire status_pkg::op_req_type      op_req,
  input  wire status_pkg::reset_event_type reset_events,
  input  wire logic                        brownout_reset_enable,
  output status_pkg::op_result_type        op_result,
  output status_pkg::alu_flags_type        alu_flags,
  output status_pkg::reset_cause_type      reset_cause_register
);

  //--------------------------------------------------------------------
  // Declarations
  //--------------------------------------------------------------------
  logic [11:0]               aw_addr;
  logic [31:0]               w_data;
  logic [3:0]                w_strb;
  logic                      wr_do;
  logic                      wr_hit_flags;
  logic                      wr_hit_cause;
  logic                      rd_hit_flags;
  logic                      rd_hit_cause;
  logic                      flags_fw_write;
  logic                      cause_fw_write;
  logic [7:0]                calc_result;
  logic                      calc_affects;
  status_pkg::alu_flags_type calc_flags;
  logic [31:0]               next_rdata;

  //--------------------------------------------------------------------
  // Address decode
  //--------------------------------------------------------------------
  // Low two address bits ignored, every register is one aligned word
  assign wr_hit_flags = (aw_addr[11:2] == status_pkg::FLAGS_OFFSET[11:2]);
  assign wr_hit_cause =
    (aw_addr[11:2] == status_pkg::RESET_CAUSE_OFFSET[11:2]);
  assign rd_hit_flags = (araddr[11:2] == status_pkg::FLAGS_OFFSET[11:2]);
  assign rd_hit_cause =
    (araddr[11:2] == status_pkg::RESET_CAUSE_OFFSET[11:2]);

  // Both halves held and no answer pending: commit the write now
  assign wr_do = !awready && !wready && !bvalid;

  // Data sits in byte lane 0; a write without that lane changes nothing
  assign flags_fw_write = wr_do && wr_hit_flags && w_strb[0];
  assign cause_fw_write = wr_do && wr_hit_cause && w_strb[0];

  //--------------------------------------------------------------------
  // Write address channel
  //--------------------------------------------------------------------
  // Ready drops once an address is held, until its response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      aw_addr <= 12'h000;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_addr <= awaddr;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  //--------------------------------------------------------------------
  // Write data channel
  //--------------------------------------------------------------------
  // Taken independently of the address, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b1;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_data <= wdata;
      w_strb <= wstrb;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  //--------------------------------------------------------------------
  // Write response channel
  //--------------------------------------------------------------------
  // Unmapped addresses answer with a slave error and write nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= status_pkg::RESP_OKAY;
    end else if (wr_do) begin
      bvalid <= 1'b1;
      bresp  <= (wr_hit_flags || wr_hit_cause) ?
                status_pkg::RESP_OKAY : status_pkg::RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  //--------------------------------------------------------------------
  // Read path
  //--------------------------------------------------------------------
  // Read mux; upper bits of each word and reserved fields read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd_hit_flags) begin
      next_rdata = {24'h00_0000, alu_flags}; // [RL1] [RL10]
    end else if (rd_hit_cause) begin
      next_rdata = {24'h00_0000, reset_cause_register}; // [RL12]
    end
  end

  // One read in flight; data is captured when the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= status_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= next_rdata;
      rresp   <= (rd_hit_flags || rd_hit_cause) ?
                 status_pkg::RESP_OKAY : status_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  //--------------------------------------------------------------------
  // Operation datapath
  //--------------------------------------------------------------------
  alu_flag_logic flag_calc (
    .op            (op_req),
    .flags_now     (alu_flags),
    .result        (calc_result),
    .flags_new     (calc_flags),
    .affects_flags (calc_affects)
  );

  // Result leaves only when the flags are not the destination
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_result <= '0;
    end else begin
      op_result.valid <= op_req.valid && !op_req.dest_is_flags; // [RL2]
      op_result.data  <= calc_result;
    end
  end

  //--------------------------------------------------------------------
  // ALU flag register
  //--------------------------------------------------------------------
  // Core update outranks a firmware write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alu_flags <= status_pkg::alu_flags_type'(status_pkg::ALU_FLAGS_RESET);
    end else if (op_req.valid && calc_affects) begin
      // Computed result discarded when aimed at the flags
      alu_flags <= calc_flags; // [RL2] [RL3]
    end else if (op_req.valid && op_req.dest_is_flags) begin
      alu_flags <= status_pkg::alu_flags_type'(
                     calc_result & status_pkg::ALU_FLAGS_WRITE_MASK
                   ); // [RL1] [RL4] [RL10]
    end else if (flags_fw_write) begin
      alu_flags <= status_pkg::alu_flags_type'(
                     w_data[7:0] & status_pkg::ALU_FLAGS_WRITE_MASK
                   ); // [RL1] [RL10]
    end
  end

  //--------------------------------------------------------------------
  // Reset-cause register
  //--------------------------------------------------------------------
  // Priority enable leaves as a register bit for the interrupt logic
  reset_cause_keeper cause_keeper (
    .aclk                  (aclk),
    .aresetn               (aresetn),
    .brownout_reset_enable (brownout_reset_enable),
    .events                (reset_events),
    .fw_write              (cause_fw_write),
    .fw_data               (w_data[7:0]),
    .cause                 (reset_cause_register)
  );

endmodule

// ==== test/alu_status_reset_cause_asserts.sv ====
// Port-level checker for the flag and reset-cause bank
`timescale 1ns/100ps
module alu_status_reset_cause_asserts (
  input wire logic                        aclk,
  input wire logic                        aresetn,
  input wire logic                        awvalid,
  input wire logic                        awready,
  input wire logic                        wvalid,
  input wire logic                        wready,
  input wire logic [1:0]                  bresp,
  input wire logic                        bvalid,
  input wire logic                        bready,
  input wire logic                        arvalid,
  input wire logic                        arready,
  input wire logic [31:0]                 rdata,
  input wire logic                        rvalid,
  input wire logic                        rready,
  input wire status_pkg::op_req_type      op_req,
  input wire status_pkg::reset_event_type reset_events,
  input wire status_pkg::op_result_type   op_result,
  input wire status_pkg::alu_flags_type   alu_flags,
  input wire status_pkg::reset_cause_type reset_cause_register
);
  logic [8:0] sum_q;

  // ------------------------------------------------------------------
  // Helper logic and defaults
  // ------------------------------------------------------------------
  // Nine-bit sum of the last operands, so the carry out is visible
  always_ff @(posedge aclk) begin
    sum_q <= {1'b0, op_req.operand_a} + op_req.operand_b;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_write_answer: assert property (
    awvalid && awready && wvalid && wready |=> ##1 bvalid)
    else $error("write response did not follow the handshakes");
  a_resp_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before bready");
  a_read_answer: assert property (
    arvalid && arready |=> rvalid && !arready)
    else $error("read data did not follow the address");
  a_read_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before rready");
  a_flags_top_zero: assert property (
    alu_flags.unused == 3'h0)
    else $error("flag bits 7 to 5 not zero");
  a_cause_gap_zero: assert property (
    reset_cause_register.unused == 2'h0)
    else $error("reset-cause bits 6 and 5 not zero");
  a_add_flags: assert property (
    op_req.valid && !op_req.dest_is_flags &&
    op_req.code == status_pkg::ACCUMULATOR_ADD_OP |=>
    alu_flags.carry == sum_q[8] && alu_flags.negative == sum_q[7] &&
    alu_flags.zero == (sum_q[7:0] == 8'h00))
    else $error("add flags wrong");
  a_keep_flags: assert property (
    op_req.valid && !op_req.dest_is_flags &&
    op_req.code >= status_pkg::BIT_SET_OP &&
    op_req.code <= status_pkg::ACCUMULATOR_STORE_OP |=>
    $stable(alu_flags) || $rose(bvalid))
    else $error("flag-neutral op changed the flags");
  a_dest_no_result: assert property (
    op_req.valid && op_req.dest_is_flags |=> !op_result.valid)
    else $error("op into the flags produced a result");
  a_timeout_clears: assert property (
    reset_events.watchdog_timeout |=>
    !reset_cause_register.watchdog_expiry_flag)
    else $error("time-out left the expiry flag set");
  a_sleep_clears: assert property (
    reset_events.sleep |=> !reset_cause_register.sleep_entry_flag)
    else $error("sleep left the sleep-entry flag set");
  a_soft_clears: assert property (
    reset_events.soft_reset |=> !reset_cause_register.soft_reset_flag)
    else $error("reset instruction left its flag set");
  a_brown_clears: assert property (
    reset_events.brownout |=>
    !reset_cause_register.low_voltage_reset_flag)
    else $error("brown-out left the low-voltage flag set");

  // Main scenarios reached
  c_write: cover property (bvalid && bready);
  c_read: cover property (rvalid && rready);
  c_timeout: cover property (reset_events.watchdog_timeout);
endmodule

bind alu_status_reset_cause alu_status_reset_cause_asserts
  alu_status_reset_cause_asserts_i (.aclk, .aresetn, .awvalid, .awready,
  .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata,
  .rvalid, .rready, .op_req, .reset_events, .op_result, .alu_flags,
  .reset_cause_register);

// ==== test/testbench.sv ====
// Self-checking bench for the flag and reset-cause bank
`timescale 1ns/100ps
module testbench;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b1; // Answers are always accepted
  logic        arvalid = 1'b0;
  logic        rready = 1'b1;
  logic        brown_en = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [4:0]  evm [7] = '{5'h10, 5'h08, 5'h02, 5'h04, 5'h01, 5'h06, 5'h0A};
  logic [7:0]  eve [7] = '{8'h8F, 8'h87, 8'h8F, 8'h8B, 8'h8A, 8'h8A, 8'h86};
  int          err_count = 0;
  int          checked = 0;
  int          cycles = 0;
  status_pkg::op_req_type      op_req = '0;
  status_pkg::reset_event_type reset_events = '0;
  status_pkg::op_result_type   op_result;
  status_pkg::alu_flags_type   alu_flags;
  status_pkg::reset_cause_type cause;
  localparam logic [11:0] flags_addr = status_pkg::FLAGS_OFFSET;
  localparam logic [11:0] cause_addr = status_pkg::RESET_CAUSE_OFFSET;

  alu_status_reset_cause alu_status_reset_cause_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .op_req(op_req), .reset_events(reset_events),
    .brownout_reset_enable(brown_en), .op_result(op_result),
    .alu_flags(alu_flags), .reset_cause_register(cause));

  // ------------------------------------------------------------------
  // Clock, hang guard and shared tasks
  // ------------------------------------------------------------------
  always #5 aclk = ~aclk;

  // Tests need about 130 cycles; a hang stops well after that
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] seen,
                       input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, want, seen);
    end
  endtask

  task automatic do_reset(input logic en);
    brown_en <= en;
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // Address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (n < 50) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready === 1'b1)
        awvalid <= 1'b0;
      if (wvalid && wready === 1'b1)
        wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        check("bresp", 32'(bresp), 32'(er));
        n = 99;
      end
    end
    if (n != 99)
      err_count++;
  endtask

  // Upper read bits must come back zero as well
  task automatic rd(input string s, input logic [11:0] a,
                    input logic [7:0] e, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    while (n < 50) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        check(s, rdata, {24'h00_0000, e});
        check("rresp", 32'(rresp), 32'(er));
        n = 99;
      end
    end
    if (n != 99)
      err_count++;
  endtask

  // One operation; v packs {a, b, expected result, expected flags}
  task automatic do_op(input status_pkg::op_code_type c, input logic d,
                       input logic [31:0] v);
    op_req <= {1'b1, c, d, v[31:16]};
    @(posedge aclk);
    op_req <= '0;
    @(posedge aclk);
    check("alu_flags", 32'(alu_flags), 32'(v[7:0]));
    check("op_valid", 32'(op_result.valid), 32'(!d));
    if (!d)
      check("op_data", 32'(op_result.data), 32'(v[15:8]));
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    do_reset(1'b1);
    rd("flags", flags_addr, 8'h00, 2'h0);
    rd("cause", cause_addr, 8'h1D, 2'h0);
    rd("unmapped", 12'h008, 8'h00, 2'h2);
    wr(12'h00C, 8'hFF, 2'h2);
    wr(cause_addr, 8'hFF, 2'h0);
    rd("cause", cause_addr, 8'h9F, 2'h0);
    foreach (evm[i]) begin
      reset_events <= evm[i];
      @(posedge aclk);
      reset_events <= '0;
      rd("cause", cause_addr, eve[i], 2'h0);
    end
    wr(cause_addr, 8'h00, 2'h0);
    rd("cause", cause_addr, 8'h04, 2'h0);
    wr(flags_addr, 8'hFF, 2'h0);
    rd("flags", flags_addr, 8'h1F, 2'h0);
    do_op(status_pkg::ACCUMULATOR_ADD_OP, 1'b0, 32'h0F01_1002);
    do_op(status_pkg::ACCUMULATOR_ADD_OP, 1'b0, 32'h8080_000D);
    do_op(status_pkg::ACCUMULATOR_ADD_OP, 1'b0, 32'h7F01_801A);
    do_op(status_pkg::ACCUMULATOR_SUBTRACT_OP, 1'b0, 32'h0505_0007);
    do_op(status_pkg::ACCUMULATOR_SUBTRACT_OP, 1'b0, 32'h1001_0F01);
    do_op(status_pkg::ACCUMULATOR_SUBTRACT_OP, 1'b0, 32'h0001_FF10);
    do_op(status_pkg::OP_AND, 1'b0, 32'hF00F_0004);
    do_op(status_pkg::OP_OR, 1'b0, 32'h8000_8010);
    do_op(status_pkg::OP_XOR, 1'b0, 32'h5555_0004);
    do_op(status_pkg::BIT_SET_OP, 1'b0, 32'h0007_8004);
    do_op(status_pkg::BIT_CLEAR_OP, 1'b0, 32'hFF03_F704);
    do_op(status_pkg::NIBBLE_EXCHANGE_OP, 1'b0, 32'h1200_2104);
    do_op(status_pkg::FILE_TO_FILE_MOVE_OP, 1'b0, 32'h3C00_3C04);
    do_op(status_pkg::ACCUMULATOR_STORE_OP, 1'b0, 32'h33C3_C304);
    do_op(status_pkg::ACCUMULATOR_ADD_OP, 1'b1, 32'hFF01_0007);
    do_op(status_pkg::CLEAR_FILE_OP, 1'b1, 32'h5A00_0007);
    do_op(status_pkg::BIT_SET_OP, 1'b1, 32'h0002_0004);
    rd("flags", flags_addr, 8'h04, 2'h0);
    do_reset(1'b0);
    rd("cause", cause_addr, 8'h1C, 2'h0);
    rd("flags", flags_addr, 8'h00, 2'h0);
    summarize();
  end
endmodule
